// ==== rtl/psec_pkg.sv ====
// package: register map, fields and command codes of the status/error capture block
// What this block does
// - at instruction end raise done or abnormal-end; neither means motor stopped
// - done/abnormal flags shared by all instructions, rewritten after each one
// - detect error when configuration, target device or number range is invalid
// - on error set live error flag and store error code
// - store failing step in 32-bit pair and 16-bit mirror valid to 32767
// - later errors overwrite live code and step; cancel clears live flag
// - restart without cancel clears error status then re-sets flag at once
// - on error also set separate latched error flag
// - latched error keeps step in own 32-bit pair and 16-bit mirror
// - latch keeps first error until forced reset; later errors ignored
// - change to active search/return/relative/absolute drive: decelerate then stop
// - refuse any program change to batch-table block in run mode
// - variable-speed change: decel stop with accel/decel, else immediate stop
// - versions below 2.20 run variable speed without accel/decel
package psec_pkg;
    localparam logic [4:0]  ADDR_STATUS      = 5'h00;
    localparam logic [4:0]  ADDR_CTRL        = 5'h04;
    localparam logic [4:0]  ADDR_ERR_CODE    = 5'h08;
    localparam logic [4:0]  ADDR_ERR_STEP    = 5'h0c;
    localparam logic [4:0]  ADDR_ERR_SHORT   = 5'h10;
    localparam logic [4:0]  ADDR_LATCH_STEP  = 5'h14;
    localparam logic [4:0]  ADDR_LATCH_SHORT = 5'h18;
    // status bits
    localparam int ST_DONE    = 0;
    localparam int ST_ABN     = 1;
    localparam int ST_ERR     = 2;
    localparam int ST_LATCH   = 3;
    localparam int ST_REFUSED = 4;
    // control bits
    localparam int CT_CANCEL  = 0;
    localparam int CT_FORCE   = 1;
    localparam int CT_RESTART = 2;
    localparam int CT_CHANGE  = 3;
    localparam int CT_RUN     = 4;
    localparam int CT_ACCDEC  = 5;
    localparam int CT_CLR_REF = 6;
    localparam logic        RUN_RESET       = 1'b0;
    localparam logic        ACCDEC_RESET    = 1'b1;
    localparam logic [15:0] VER_ACCDEC_MIN  = 16'h00dc; // 2.20 in hundredths
    localparam int          CMD_W           = 3;
    typedef enum logic [CMD_W-1:0] {
        CMD_NONE, CMD_ORIGIN_SEARCH, CMD_INTERRUPT_FEED, CMD_BATCH_TABLE,
        CMD_ZERO_RETURN, CMD_VARIABLE_SPEED, CMD_RELATIVE_DRIVE, CMD_ABSOLUTE_DRIVE
    } psec_cmd_e;
    typedef enum logic [1:0] {STOP_IDLE, STOP_DECEL, STOP_HALT} psec_stop_e;
endpackage : psec_pkg

// ==== rtl/psec_step_store.sv ====
// step number store with 32-bit pair and 16-bit mirror
`timescale 1ns/10ps
module psec_step_store
    import psec_pkg::*;
#(
    parameter int STEP_W  = 32,
    parameter int SHORT_W = 16
) (
    input  wire logic               clk,     // clock
    input  wire logic               rst_n,   // synced reset
    input  wire logic               ce,      // clock enable
    input  wire logic               capture, // store step now
    input  wire logic               clear,   // zero stored data
    input  wire logic [STEP_W-1:0]  step,    // step number in
    output logic      [STEP_W-1:0]  step_q,  // stored pair
    output logic      [SHORT_W-1:0] short_q  // 16-bit mirror
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_q  <= '0;
            short_q <= '0;
        end else if (ce) begin
            if (capture) begin
                step_q  <= step;
                short_q <= step[SHORT_W-1:0];
            end else if (clear) begin
                step_q  <= '0;
                short_q <= '0;
            end
        end
    end
endmodule : psec_step_store

// ==== rtl/psec_run_change.sv ====
// stop decision when the program changes during run
`timescale 1ns/10ps
module psec_run_change
    import psec_pkg::*;
(
    input  wire logic             clk,        // clock
    input  wire logic             rst_n,      // synced reset
    input  wire logic             ce,         // clock enable
    input  wire logic             change,     // program change in run
    input  wire logic [CMD_W-1:0] cmd,        // active instruction
    input  wire logic             busy,       // pulses being emitted
    input  wire logic             accdec_ok,  // variable speed ramps
    output logic                  decel_stop, // decelerating stop
    output logic                  imm_stop,   // immediate stop
    output logic                  refused     // change refused, pulse
);
    psec_stop_e state;
    psec_stop_e next_state;
    psec_cmd_e  c;

    always_comb begin
        c = psec_cmd_e'(cmd);
        next_state = state;
        case (state)
            STOP_IDLE: begin
                if (change && busy) begin
                    case (c)
                        CMD_ORIGIN_SEARCH, CMD_INTERRUPT_FEED, CMD_ZERO_RETURN,
                        CMD_RELATIVE_DRIVE, CMD_ABSOLUTE_DRIVE: begin
                            next_state = STOP_DECEL;
                        end
                        CMD_VARIABLE_SPEED: begin
                            next_state = accdec_ok ? STOP_DECEL : STOP_HALT;
                        end
                        default: next_state = STOP_IDLE;
                    endcase
                end
            end
            STOP_DECEL, STOP_HALT: begin
                if (!busy) next_state = STOP_IDLE;
            end
            default: next_state = STOP_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= STOP_IDLE;
            decel_stop <= 1'b0;
            imm_stop   <= 1'b0;
        end else if (ce) begin
            state      <= next_state;
            decel_stop <= next_state == STOP_DECEL;
            imm_stop   <= next_state == STOP_HALT;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refused <= 1'b0;
        end else if (ce) begin
            refused <= change && psec_cmd_e'(cmd) == CMD_BATCH_TABLE;
        end
    end

    refuse_batch_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && change && cmd == CMD_BATCH_TABLE |=> refused && !decel_stop && !imm_stop)
        else $error("batch table change not refused");
    halt_vs_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && state == STOP_IDLE && change && busy && cmd == CMD_VARIABLE_SPEED
        && !accdec_ok |=> imm_stop && !decel_stop)
        else $error("variable speed without ramp did not halt");
    decel_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && state == STOP_IDLE && change && busy
        && (cmd == CMD_RELATIVE_DRIVE || cmd == CMD_ABSOLUTE_DRIVE) |=> decel_stop)
        else $error("drive change did not decelerate");
endmodule : psec_run_change

// ==== rtl/psec_top.sv ====
// positioning status and operation error capture with Avalon-MM registers
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module psec_top
    import psec_pkg::*;
#(
    parameter int STEP_W  = 32,
    parameter int SHORT_W = 16,
    parameter int CODE_W  = 16
) (
    input  wire logic               CLK,                     // 25 MHz clock
    input  wire logic               RESET_N,                 // async reset
    input  wire logic               CE,                      // clock enable
    input  wire logic [4:0]         ADDRESS,                 // byte address
    input  wire logic               READ,                    // read request
    input  wire logic               WRITE,                   // write request
    input  wire logic [31:0]        WRITEDATA,               // write data
    input  wire logic [3:0]         BYTEENABLE,              // byte lanes
    output logic      [31:0]        READDATA,                // read data
    output logic                    WAITREQUEST,             // stall
    input  wire logic               INSTR_START,             // instruction starts
    input  wire logic               INSTR_END,               // pulse output finished
    input  wire logic               INSTR_ABORT,             // end was abnormal
    input  wire logic               EXEC_STROBE,             // instruction executes
    input  wire logic               CFG_BAD,                 // bad configuration
    input  wire logic               DEV_BAD,                 // bad target device
    input  wire logic               RANGE_BAD,               // bad device range
    input  wire logic [CODE_W-1:0]  ERR_CODE_IN,             // code of this error
    input  wire logic [STEP_W-1:0]  STEP_IN,                 // step executing
    input  wire logic [CMD_W-1:0]   ACTIVE_CMD,              // active instruction
    input  wire logic               PULSE_BUSY,              // pulses being output
    input  wire logic [15:0]        FW_VERSION,              // version, hundredths
    output logic                    INSTR_DONE_FLAG,         // normal completion
    output logic                    INSTR_ABNORMAL_END_FLAG, // abnormal end
    output logic                    OP_ERROR_FLAG,           // live error
    output logic                    OP_ERROR_LATCH_FLAG,     // first error held
    output logic                    DECEL_STOP,              // decelerate and stop
    output logic                    IMM_STOP,                // stop pulses now
    output logic                    CHANGE_REFUSED           // change refused pulse
);
    logic               rst_s1;
    logic               rst_n_i;
    logic               wait_q;
    logic               req;
    logic               acc;
    logic               wr_ctrl;
    logic               cancel_p;
    logic               force_p;
    logic               restart_p;
    logic               change_p;
    logic               clr_ref_p;
    logic               run_mode;
    logic               accdec_en;
    logic               accdec_ok;
    logic               err_evt;
    logic               restart_pend;
    logic               refused_sticky;
    logic [CODE_W-1:0]  op_error_code_reg;
    logic [STEP_W-1:0]  op_error_step_pair;
    logic [SHORT_W-1:0] op_error_step_short;
    logic [STEP_W-1:0]  latched_step_pair;
    logic [SHORT_W-1:0] latched_step_short;

    // reset release through two flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_s1  <= 1'b0;
            rst_n_i <= 1'b0;
        end else begin
            rst_s1  <= 1'b1;
            rst_n_i <= rst_s1;
        end
    end

    // bus: one wait cycle, access takes effect when waitrequest is low
    assign req       = READ | WRITE;
    assign acc       = CE && req && !wait_q;
    assign wr_ctrl   = acc && WRITE && ADDRESS == ADDR_CTRL && BYTEENABLE[0];
    assign cancel_p  = wr_ctrl && WRITEDATA[CT_CANCEL];
    assign force_p   = wr_ctrl && WRITEDATA[CT_FORCE];
    assign restart_p = wr_ctrl && WRITEDATA[CT_RESTART];
    assign change_p  = wr_ctrl && WRITEDATA[CT_CHANGE] && run_mode;
    assign clr_ref_p = wr_ctrl && WRITEDATA[CT_CLR_REF];

    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
        end else if (CE) begin
            wait_q <= !(req && wait_q);
        end
    end
    assign WAITREQUEST = wait_q;

    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            READDATA <= '0;
        end else if (CE && req && wait_q && READ) begin
            READDATA <= '0;
            case (ADDRESS)
                ADDR_STATUS: begin
                    READDATA[ST_DONE]    <= INSTR_DONE_FLAG;
                    READDATA[ST_ABN]     <= INSTR_ABNORMAL_END_FLAG;
                    READDATA[ST_ERR]     <= OP_ERROR_FLAG;
                    READDATA[ST_LATCH]   <= OP_ERROR_LATCH_FLAG;
                    READDATA[ST_REFUSED] <= refused_sticky;
                end
                ADDR_CTRL: begin
                    READDATA[CT_RUN]    <= run_mode;
                    READDATA[CT_ACCDEC] <= accdec_en;
                end
                ADDR_ERR_CODE:    READDATA[CODE_W-1:0]  <= op_error_code_reg;
                ADDR_ERR_STEP:    READDATA[STEP_W-1:0]  <= op_error_step_pair;
                ADDR_ERR_SHORT:   READDATA[SHORT_W-1:0] <= op_error_step_short;
                ADDR_LATCH_STEP:  READDATA[STEP_W-1:0]  <= latched_step_pair;
                ADDR_LATCH_SHORT: READDATA[SHORT_W-1:0] <= latched_step_short;
                default:          READDATA <= '0;
            endcase
        end
    end

    // control register fields
    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_mode  <= RUN_RESET;
            accdec_en <= ACCDEC_RESET;
        end else if (wr_ctrl) begin
            run_mode  <= WRITEDATA[CT_RUN];
            accdec_en <= WRITEDATA[CT_ACCDEC];
        end
    end

    // completion flags, rewritten by every instruction
    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            INSTR_DONE_FLAG         <= 1'b0;
            INSTR_ABNORMAL_END_FLAG <= 1'b0;
        end else if (CE) begin
            if (INSTR_END) begin
                INSTR_DONE_FLAG         <= !INSTR_ABORT;
                INSTR_ABNORMAL_END_FLAG <= INSTR_ABORT;
            end else if (INSTR_START) begin
                INSTR_DONE_FLAG         <= 1'b0;
                INSTR_ABNORMAL_END_FLAG <= 1'b0;
            end
        end
    end

    assign err_evt = EXEC_STROBE && (CFG_BAD || DEV_BAD || RANGE_BAD);

    // live error flag; new error wins over cancel
    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            OP_ERROR_FLAG <= 1'b0;
            restart_pend  <= 1'b0;
        end else if (CE) begin
            restart_pend <= restart_p && !cancel_p && OP_ERROR_FLAG && !err_evt;
            if (err_evt || restart_pend) begin
                OP_ERROR_FLAG <= 1'b1;
            end else if (cancel_p || restart_p) begin
                OP_ERROR_FLAG <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_error_code_reg <= '0;
        end else if (CE && err_evt) begin
            op_error_code_reg <= ERR_CODE_IN;
        end
    end

    // first-error latch; forced reset clears it unless an error coincides
    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            OP_ERROR_LATCH_FLAG <= 1'b0;
        end else if (CE) begin
            if (err_evt) begin
                OP_ERROR_LATCH_FLAG <= 1'b1;
            end else if (force_p) begin
                OP_ERROR_LATCH_FLAG <= 1'b0;
            end
        end
    end

    psec_step_store #(
        .STEP_W  (STEP_W),
        .SHORT_W (SHORT_W)
    ) u_live (
        .clk     (CLK),
        .rst_n   (rst_n_i),
        .ce      (CE),
        .capture (err_evt),
        .clear   (1'b0),
        .step    (STEP_IN),
        .step_q  (op_error_step_pair),
        .short_q (op_error_step_short)
    );

    psec_step_store #(
        .STEP_W  (STEP_W),
        .SHORT_W (SHORT_W)
    ) u_latch (
        .clk     (CLK),
        .rst_n   (rst_n_i),
        .ce      (CE),
        .capture (err_evt && (!OP_ERROR_LATCH_FLAG || force_p)),
        .clear   (force_p),
        .step    (STEP_IN),
        .step_q  (latched_step_pair),
        .short_q (latched_step_short)
    );

    // variable speed ramps only from version 2.20
    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            accdec_ok <= 1'b0;
        end else if (CE) begin
            accdec_ok <= accdec_en && FW_VERSION >= VER_ACCDEC_MIN;
        end
    end

    psec_run_change u_change (
        .clk        (CLK),
        .rst_n      (rst_n_i),
        .ce         (CE),
        .change     (change_p),
        .cmd        (ACTIVE_CMD),
        .busy       (PULSE_BUSY),
        .accdec_ok  (accdec_ok),
        .decel_stop (DECEL_STOP),
        .imm_stop   (IMM_STOP),
        .refused    (CHANGE_REFUSED)
    );

    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            refused_sticky <= 1'b0;
        end else if (CE) begin
            if (CHANGE_REFUSED) begin
                refused_sticky <= 1'b1;
            end else if (clr_ref_p) begin
                refused_sticky <= 1'b0;
            end
        end
    end

    sequence restart_s;
        CE && restart_p && !cancel_p && OP_ERROR_FLAG && !err_evt;
    endsequence

    sequence err_s;
        CE && err_evt;
    endsequence

    flags_excl_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        !(INSTR_DONE_FLAG && INSTR_ABNORMAL_END_FLAG))
        else $error("done and abnormal end both set");
    end_flag_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        CE && INSTR_END |=> INSTR_DONE_FLAG != INSTR_ABNORMAL_END_FLAG
        && INSTR_ABNORMAL_END_FLAG == $past(INSTR_ABORT))
        else $error("completion flag not set at end");
    err_capture_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        err_s |=> OP_ERROR_FLAG && op_error_code_reg == $past(ERR_CODE_IN)
        && op_error_step_pair == $past(STEP_IN))
        else $error("live error not captured");
    err_short_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        err_s |=> op_error_step_short == $past(STEP_IN[SHORT_W-1:0]))
        else $error("step mirror mismatch");
    cancel_clear_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        CE && cancel_p && !err_evt && !restart_pend |=> !OP_ERROR_FLAG)
        else $error("cancel did not clear error flag");
    restart_drop_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        restart_s |=> !OP_ERROR_FLAG && restart_pend)
        else $error("restart did not clear error status");
    restart_back_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        CE && restart_pend |=> OP_ERROR_FLAG)
        else $error("error flag not re-set after restart");
    latch_set_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        err_s |=> OP_ERROR_LATCH_FLAG)
        else $error("latch flag not set");
    latch_hold_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        err_s and OP_ERROR_LATCH_FLAG && !force_p |=> $stable(latched_step_pair))
        else $error("latched step overwritten");
    wait_one_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        CE && req && wait_q |=> !wait_q ##1 wait_q)
        else $error("waitrequest did not pulse low once");

    // first-error latch, forced reset, flag housekeeping and ramp version check
    latch_first_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        err_s and !OP_ERROR_LATCH_FLAG |=> latched_step_pair == $past(STEP_IN)
        && latched_step_short == $past(STEP_IN[SHORT_W-1:0]))
        else $error("first error step not latched");
    force_clear_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        CE && force_p && !err_evt |=> !OP_ERROR_LATCH_FLAG
        && latched_step_pair == '0 && latched_step_short == '0)
        else $error("forced reset did not clear latch");
    start_clear_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        CE && INSTR_START && !INSTR_END |=> !INSTR_DONE_FLAG && !INSTR_ABNORMAL_END_FLAG)
        else $error("completion flags not cleared at start");
    ramp_version_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        CE && FW_VERSION < VER_ACCDEC_MIN |=> !accdec_ok)
        else $error("ramp allowed on old version");
    refused_keep_a: assert property (@(posedge CLK) disable iff (!rst_n_i)
        CE && CHANGE_REFUSED |=> refused_sticky)
        else $error("refused status not kept");
endmodule : psec_top

// ==== sim/psec_servo_model.sv ====
// servo amplifier model: takes the pulse train, reports positioning complete
`timescale 1ns/10ps
module psec_servo_model #(
    parameter int MAX_HZ    = 100000, // pulse input ceiling
    parameter int DECEL_CYC = 6
) (
    input  wire logic clk,    // clock
    input  wire logic go,     // motion starts, pulse format matches drive
    input  wire logic decel,  // decelerate and stop
    input  wire logic halt,   // stop pulses now
    output logic      busy,   // pulses arriving
    output logic      in_pos  // positioning complete
);
    int cnt = 0;
    initial begin
        busy = 1'b0;
        in_pos = 1'b1;
    end
    always @(posedge clk) begin // go wins over halt, halt over decel
        if (go) begin
            busy <= 1'b1;
            in_pos <= 1'b0;
            cnt <= DECEL_CYC;
        end else if (halt && busy) begin
            busy <= 1'b0;
        end else if (decel && busy) begin
            cnt <= cnt - 1;
            busy <= (cnt != 1);
        end else if (!busy && !in_pos) begin // motor settles after last pulse
            cnt <= cnt - 1;
            in_pos <= (cnt <= 1);
        end
    end
endmodule : psec_servo_model

// ==== sim/test_positioning_status_error_capture.sv ====
// self-checking bench for the status and error capture block
`timescale 1ns/10ps
module test_positioning_status_error_capture
    import psec_pkg::*;
;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, st = 0, fn = 0, ab = 0, ex = 0, go = 0;
    logic cb = 0, db = 0, rb = 0, wait_n, done, abn, oerr, latch, dec, imm, refp, busy, inpos;
    logic [4:0]  adr = 0;
    logic [31:0] wd = 0, rdata, stp = 0, s0, s;
    logic [15:0] code = 0, fw = 16'h00dc, c;
    logic [2:0]  acmd = 0;
    logic [3:0]  be = 4'hf;
    logic [1:0]  own_flags;
    logic [63:0] exp_q[$];
    logic [31:0] seed = 64;
    int miscompares = 0, num_checks = 0;
    psec_cmd_e   dcmd[5] = '{CMD_ORIGIN_SEARCH, CMD_INTERRUPT_FEED, CMD_ZERO_RETURN,
                             CMD_RELATIVE_DRIVE, CMD_ABSOLUTE_DRIVE};
    always #20 clk = ~clk;
    psec_top u_psec_top (.CLK(clk), .RESET_N(rst_n), .CE(1'b1), .ADDRESS(adr), .READ(rd),
        .WRITE(wr), .WRITEDATA(wd), .BYTEENABLE(be), .READDATA(rdata), .WAITREQUEST(wait_n),
        .INSTR_START(st), .INSTR_END(fn), .INSTR_ABORT(ab), .EXEC_STROBE(ex), .CFG_BAD(cb),
        .DEV_BAD(db), .RANGE_BAD(rb), .ERR_CODE_IN(code), .STEP_IN(stp), .ACTIVE_CMD(acmd),
        .PULSE_BUSY(busy), .FW_VERSION(fw), .INSTR_DONE_FLAG(done),
        .INSTR_ABNORMAL_END_FLAG(abn), .OP_ERROR_FLAG(oerr), .OP_ERROR_LATCH_FLAG(latch),
        .DECEL_STOP(dec), .IMM_STOP(imm), .CHANGE_REFUSED(refp));
    psec_servo_model u_psec_servo_model (.clk(clk), .go(go), .decel(dec), .halt(imm),
        .busy(busy), .in_pos(inpos));
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        do @(posedge clk); while (wait_n !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rx(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e});
        bus(1'b0, a, 32'h0);
    endtask : rx
    // read results are compared in arrival order against the noted values
    always @(posedge clk) begin
        if (rd === 1'b1 && wait_n === 1'b0 && exp_q.size() > 0) begin
            chk(rdata & exp_q[0][63:32], exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
    end
    task automatic fin(input logic abort);
        @(posedge clk) st <= 1'b1;
        @(posedge clk) st <= 1'b0;
        fn <= 1'b1;
        ab <= abort;
        @(posedge clk) fn <= 1'b0;
        @(posedge clk) own_flags = {abn, done}; // private copy
        @(posedge clk) chk(own_flags, {abort, !abort});
    endtask : fin
    task automatic err(input int k, input logic [15:0] ec, input logic [31:0] sn);
        @(posedge clk) ex <= 1'b1;
        cb <= (k == 0);
        db <= (k == 1);
        rb <= (k == 2);
        code <= ec;
        stp <= sn;
        @(posedge clk) ex <= 1'b0;
        {cb, db, rb} <= 3'b000;
        repeat (2) @(posedge clk);
        chk({latch, oerr}, 2'b11);
    endtask : err
    task automatic stopcase(input psec_cmd_e cm, input logic [31:0] ct, input logic [15:0] v,
                            input logic [1:0] e);
        int n;
        bus(1'b1, ADDR_CTRL, ct);
        fw <= v;
        acmd <= cm;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        repeat (3) @(posedge clk);
        bus(1'b1, ADDR_CTRL, ct | 32'h8);
        for (n = 0; n < 20 && (dec | imm) !== 1'b1; n++) @(posedge clk);
        chk({dec, imm}, e);
        for (n = 0; n < 60 && inpos !== 1'b1; n++) @(posedge clk);
        chk(busy, 1'b0);
    endtask : stopcase
    task automatic final_report();
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        #(40 * 20000);
        miscompares++;
        final_report();
    end
    initial begin
        logic lo;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rx(ADDR_STATUS, 32'h0, 32'h1f);
        rx(ADDR_CTRL, 32'h20, '1);
        rx(5'h1c, 32'h0, '1);
        fin(1'b0);
        rx(ADDR_STATUS, 32'h1, 32'h3);
        fin(1'b1);
        rx(ADDR_STATUS, 32'h2, 32'h3);
        for (int k = 0; k < 3; k++) begin
            c = 16'(xorshift());
            s = (k == 2) ? 32'd32767 : xorshift();
            if (k == 0) s0 = s;
            err(k, c, s);
            rx(ADDR_ERR_CODE, {16'h0, c}, '1);
            rx(ADDR_ERR_STEP, s, '1);
            rx(ADDR_ERR_SHORT, {16'h0, s[15:0]}, '1);
            rx(ADDR_LATCH_STEP, s0, '1);
            rx(ADDR_LATCH_SHORT, {16'h0, s0[15:0]}, '1);
            rx(ADDR_STATUS, 32'hc, 32'hc);
        end
        be <= 4'he;
        bus(1'b1, ADDR_CTRL, 32'h1);
        be <= 4'hf;
        rx(ADDR_STATUS, 32'hc, 32'hc);
        bus(1'b1, ADDR_CTRL, 32'h1);
        rx(ADDR_STATUS, 32'h8, 32'hc);
        err(0, c, s);
        bus(1'b1, ADDR_CTRL, 32'h4);
        lo = 1'b0;
        repeat (4) @(posedge clk) if (oerr === 1'b0) lo = 1'b1;
        chk({lo, oerr}, 2'b11);
        bus(1'b1, ADDR_CTRL, 32'h2);
        rx(ADDR_LATCH_STEP, 32'h0, '1);
        rx(ADDR_STATUS, 32'h0, 32'h8);
        s = xorshift();
        err(1, c, s);
        rx(ADDR_LATCH_STEP, s, '1);
        foreach (dcmd[i]) stopcase(dcmd[i], 32'h30, 16'h00dc, 2'b10);
        stopcase(CMD_VARIABLE_SPEED, 32'h30, 16'h00dc, 2'b10);
        stopcase(CMD_VARIABLE_SPEED, 32'h10, 16'h00dc, 2'b01);
        stopcase(CMD_VARIABLE_SPEED, 32'h30, 16'h00db, 2'b01);
        acmd <= CMD_BATCH_TABLE; // changes only while no pulses
        bus(1'b1, ADDR_CTRL, 32'h38);
        @(posedge clk) chk(refp, 1'b1);
        rx(ADDR_STATUS, 32'h10, 32'h10);
        bus(1'b1, ADDR_CTRL, 32'h60);
        bus(1'b1, ADDR_CTRL, 32'h28);
        @(posedge clk) chk(refp, 1'b0);
        rx(ADDR_STATUS, 32'h0, 32'h10);
        repeat (3) @(posedge clk);
        final_report();
    end
endmodule : test_positioning_status_error_capture
